// ==== src/adcsc_core.sv ====
// Decided for this implementation: the register offsets and the AXI4-Lite slave port.
`timescale 1ns/100ps
`include "adcsc_regs.svh"
// Notes on behaviour
// R01: samples go to the host only once the FIFO is half full.
// R02: forced update drains every held sample, even below half full.
// R03: forced update is ignored in bus-mastering mode.
// R04: each software scan clock acquires exactly one scan of the channel list.
// R05: conversions can be enabled or disabled at any time.
// R06: a clear command empties the sample FIFO.
// R07: timebase defaults to slow; a control bit selects the fast one.
// R08: scan rate is the timebase divided by the host divider.
// R09: host keeps scan rate times list length within board maximum.
// R10: FIFO overflow raises the overflow error event.
// R11: frame event fires for each complete frame in the host buffer.
// R12: single run stops when host buffer fills, flagging full and halted.
// R13: after start, converting begins only on the configured start trigger.
// R14: every restart writes from the beginning of the host buffer.
// R15: host reads polled FIFO before it fills under external clock.
// R16: a slow flag on an entry adds settling time before conversion.
// R17: half full means occupancy at least half the depth, checked per sample.
module adcsc_core import adcsc_pkg::*; #(
   parameter int DEPTH = 8,
   parameter int LIST_LEN = 16
) (
   input wire logic clk,
   input wire logic srst,
   input wire logic ce,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic extScanClk,
   input wire logic hwStartTrig,
   output logic [7:0] adcChan,
   output logic adcStart,
   input wire logic [15:0] adcData,
   input wire logic adcDone,
   output adcsc_sample_t hostData,
   output logic hostValid,
   input wire logic hostReady,
   output logic [15:0] hostWrIndex
);
   localparam int LW = $clog2(DEPTH);
   localparam int IW = $clog2(LIST_LEN);

   ////////////////////////////////////////////////////////////////////////
   // register bus
   logic [31:0] ctrl_q, ctrl_d, div_q, div_d, frame_q, frame_d, bufLen_q, bufLen_d;
   logic [3:0] evt_q, evt_d;
   logic [IW:0] chCnt_q, chCnt_d;
   adcsc_entry_t chList [LIST_LEN];
   logic awHeld_q, awHeld_d, wHeld_q, wHeld_d, bv_q, bv_d, rv_q, rv_d;
   logic [7:0] awAddr_q, awAddr_d;
   logic [31:0] wData_q, wData_d, rData_q, rData_d;
   logic [1:0] bResp_q, bResp_d, rResp_q, rResp_d;
   logic wrFire;
   logic [5:0] cmd;
   logic [3:0] evtSet;
   logic [3:0] evtClr;
   logic [LW:0] level;
   adcsc_acq_t acq_q, acq_d;

   assign s_axi_awready = !awHeld_q;
   assign s_axi_wready = !wHeld_q;
   assign s_axi_bvalid = bv_q;
   assign s_axi_bresp = bResp_q;
   assign s_axi_arready = !rv_q;
   assign s_axi_rvalid = rv_q;
   assign s_axi_rdata = rData_q;
   assign s_axi_rresp = rResp_q;
   assign wrFire = awHeld_q && wHeld_q && !bv_q;
   assign cmd = (wrFire && awAddr_q == `ADCSC_CMD_OFS) ? wData_q[5:0] : 6'h00;
   assign evtClr = (wrFire && awAddr_q == `ADCSC_EVT_OFS) ? wData_q[3:0] : 4'h0;

   // address and data latch in either order; write lands when both are held
   always_comb begin
      awHeld_d = awHeld_q;
      wHeld_d = wHeld_q;
      awAddr_d = awAddr_q;
      wData_d = wData_q;
      bv_d = bv_q;
      bResp_d = bResp_q;
      ctrl_d = ctrl_q;
      div_d = div_q;
      frame_d = frame_q;
      bufLen_d = bufLen_q;
      chCnt_d = chCnt_q;
      if (s_axi_awvalid && !awHeld_q) begin
         awHeld_d = 1'b1;
         awAddr_d = s_axi_awaddr;
      end
      if (s_axi_wvalid && !wHeld_q) begin
         wHeld_d = 1'b1;
         wData_d = s_axi_wdata;
      end
      if (wrFire) begin
         awHeld_d = 1'b0;
         wHeld_d = 1'b0;
         bv_d = 1'b1;
         bResp_d = 2'b00;
         unique case (awAddr_q)
            `ADCSC_CTRL_OFS: ctrl_d = wData_q; // R05 R07
            `ADCSC_DIV_OFS: div_d = wData_q;
            `ADCSC_FRAME_OFS: frame_d = wData_q;
            `ADCSC_BUFLEN_OFS: bufLen_d = wData_q;
            `ADCSC_CHCNT_OFS: chCnt_d = wData_q[IW:0];
            `ADCSC_CMD_OFS, `ADCSC_EVT_OFS, `ADCSC_CHLIST_OFS: ;
            default: bResp_d = 2'b10;
         endcase
      end
      if (bv_q && s_axi_bready) bv_d = 1'b0;
   end

   // read answer one cycle after the address is taken
   always_comb begin
      rv_d = rv_q;
      rData_d = rData_q;
      rResp_d = rResp_q;
      if (s_axi_arvalid && !rv_q) begin
         rv_d = 1'b1;
         rResp_d = 2'b00;
         unique case (s_axi_araddr)
            `ADCSC_CTRL_OFS: rData_d = ctrl_q;
            `ADCSC_DIV_OFS: rData_d = div_q;
            `ADCSC_FRAME_OFS: rData_d = frame_q;
            `ADCSC_BUFLEN_OFS: rData_d = bufLen_q;
            `ADCSC_STAT_OFS: rData_d = {8'h00, hostWrIndex[7:0], 4'h0, 4'(level), 4'h0, acq_q};
            `ADCSC_EVT_OFS: rData_d = {28'h0000000, evt_q};
            `ADCSC_CHCNT_OFS: rData_d = 32'(chCnt_q);
            `ADCSC_CMD_OFS, `ADCSC_CHLIST_OFS, `ADCSC_DATA_OFS: rData_d = 32'h0000_0000;
            default: begin
               rData_d = 32'h0000_0000;
               rResp_d = 2'b10;
            end
         endcase
      end else if (rv_q && s_axi_rready) begin
         rv_d = 1'b0;
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         awHeld_q <= 1'b0;
         wHeld_q <= 1'b0;
         awAddr_q <= 8'h00;
         wData_q <= 32'h0000_0000;
         bv_q <= 1'b0;
         bResp_q <= 2'b00;
         rv_q <= 1'b0;
         rData_q <= 32'h0000_0000;
         rResp_q <= 2'b00;
         ctrl_q <= `ADCSC_CTRL_RST;
         div_q <= `ADCSC_DIV_RST;
         frame_q <= 32'h0000_0010;
         bufLen_q <= 32'h0000_0040;
         chCnt_q <= (IW+1)'(1);
      end else if (ce) begin
         awHeld_q <= awHeld_d;
         wHeld_q <= wHeld_d;
         awAddr_q <= awAddr_d;
         wData_q <= wData_d;
         bv_q <= bv_d;
         bResp_q <= bResp_d;
         rv_q <= rv_d;
         rData_q <= rData_d;
         rResp_q <= rResp_d;
         ctrl_q <= ctrl_d;
         div_q <= div_d;
         frame_q <= frame_d;
         bufLen_q <= bufLen_d;
         chCnt_q <= chCnt_d;
      end
   end

   // channel list write: entry index in bits 19:16, slow flag bit 8
   always_ff @(posedge clk) begin
      if (ce && wrFire && awAddr_q == `ADCSC_CHLIST_OFS) begin
         chList[wData_q[16+IW-1:16]] <= adcsc_entry_t'(wData_q[8:0]); // R16
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // scan clock and acquisition state
   logic [31:0] tbAcc_q, tbAcc_d;
   logic [15:0] tbStep;
   logic extClk_q, extClk_d, scanTick, running;
   logic scanPend_q, scanPend_d;

   assign tbStep = ctrl_q[`ADCSC_CTRL_FASTTB] ? `ADCSC_TB_FAST_STEP : `ADCSC_TB_SLOW_STEP; // R07
   assign running = (acq_q == ACQ_RUN);

   // scan tick from software, external edge or internal divider
   always_comb begin
      tbAcc_d = tbAcc_q;
      extClk_d = extScanClk;
      scanTick = 1'b0;
      unique case ({ctrl_q[`ADCSC_CTRL_SCANSRC1], ctrl_q[`ADCSC_CTRL_SCANSRC0]})
         2'b00: scanTick = cmd[`ADCSC_CMD_SWCLK]; // R04
         2'b01: begin
            tbAcc_d = running ? tbAcc_q + 32'(tbStep) : 32'h0000_0000;
            if (running && tbAcc_d >= div_q && div_q != 32'h0000_0000) begin
               tbAcc_d = 32'h0000_0000;
               scanTick = 1'b1; // R08
            end
         end
         default: scanTick = extScanClk && !extClk_q;
      endcase
   end

   always_comb begin
      acq_d = acq_q;
      unique case (acq_q)
         ACQ_IDLE, ACQ_DONE: if (cmd[`ADCSC_CMD_START]) acq_d = ACQ_ARMED;
         ACQ_ARMED: begin
            if (ctrl_q[`ADCSC_CTRL_HWTRIG] ? hwStartTrig : cmd[`ADCSC_CMD_SWTRIG]) acq_d = ACQ_RUN; // R13
         end
         ACQ_RUN: if (evtSet[`ADCSC_EVT_BUFFULL] || cmd[`ADCSC_CMD_STOP]) acq_d = ACQ_DONE; // R12
         default: acq_d = ACQ_IDLE;
      endcase
      if (cmd[`ADCSC_CMD_STOP] && acq_q == ACQ_ARMED) acq_d = ACQ_IDLE;
   end

   ////////////////////////////////////////////////////////////////////////
   // conversion sequencer over the channel list
   adcsc_cnv_t cnv_q, cnv_d;
   logic [IW:0] idx_q, idx_d;
   logic [7:0] wait_q, wait_d;
   adcsc_sample_t smp;
   logic smpValid, fifoInReady;

   assign adcChan = chList[idx_q[IW-1:0]].chan;
   assign smp = '{value: adcData, chan: adcChan};

   always_comb begin
      cnv_d = cnv_q;
      idx_d = idx_q;
      wait_d = wait_q;
      scanPend_d = scanPend_q;
      adcStart = 1'b0;
      smpValid = 1'b0;
      if (scanTick && running && ctrl_q[`ADCSC_CTRL_CONVEN]) scanPend_d = 1'b1; // R05
      unique case (cnv_q)
         CNV_IDLE: begin
            if (scanPend_q) begin
               scanPend_d = 1'b0;
               idx_d = '0;
               cnv_d = CNV_SETTLE;
               wait_d = chList[0].slow ? 8'(`ADCSC_SETTLE_CYC) : 8'h00; // R16
            end
         end
         CNV_SETTLE: begin
            if (wait_q != 8'h00) wait_d = wait_q - 8'h01;
            else begin
               adcStart = 1'b1;
               cnv_d = CNV_CONV;
               wait_d = 8'(`ADCSC_CONV_CYC);
            end
         end
         CNV_CONV: begin
            if (adcDone) begin
               smpValid = 1'b1;
               if (idx_q + 1'b1 >= chCnt_q) cnv_d = CNV_IDLE; // R04
               else begin
                  idx_d = idx_q + 1'b1;
                  wait_d = chList[idx_d[IW-1:0]].slow ? 8'(`ADCSC_SETTLE_CYC) : 8'h00;
                  cnv_d = CNV_SETTLE;
               end
            end
         end
      endcase
      if (!running) begin
         cnv_d = CNV_IDLE;
         scanPend_d = 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // sample FIFO and host transfer
   logic drain_q, drain_d, fifoOutValid, flush;
   logic [15:0] wrIdx_q, wrIdx_d;
   logic [31:0] frameCnt_q, frameCnt_d;
   logic xfer;

   assign flush = cmd[`ADCSC_CMD_CLEAR]; // R06
   assign hostValid = fifoOutValid && drain_q;
   assign xfer = hostValid && hostReady;
   assign hostWrIndex = wrIdx_q;

   adcsc_fifo #(.WIDTH($bits(adcsc_sample_t)), .DEPTH(DEPTH)) u_fifo (
      .clk(clk),
      .srst(srst),
      .ce(ce),
      .flush(flush),
      .inData(smp),
      .inValid(smpValid),
      .inReady(fifoInReady),
      .outData(hostData),
      .outValid(fifoOutValid),
      .outReady(hostReady && drain_q),
      .level(level)
   );

   // drain starts at half full or on a forced update outside bus mastering, ends when empty
   always_comb begin
      drain_d = drain_q;
      if (level >= (LW+1)'(DEPTH / 2)) drain_d = 1'b1; // R01 R17
      if (cmd[`ADCSC_CMD_FORCE] && !ctrl_q[`ADCSC_CTRL_BUSMASTER]) drain_d = 1'b1; // R02 R03
      if (!fifoOutValid || flush) drain_d = 1'b0;
   end

   // host buffer position, frames and events; set wins over clear
   always_comb begin
      wrIdx_d = wrIdx_q;
      frameCnt_d = frameCnt_q;
      evtSet = 4'h0;
      if (cmd[`ADCSC_CMD_START]) begin
         wrIdx_d = 16'h0000; // R14
         frameCnt_d = 32'h0000_0000;
      end else if (xfer) begin
         wrIdx_d = wrIdx_q + 16'h0001;
         frameCnt_d = frameCnt_q + 32'h0000_0001;
         if (frameCnt_d >= frame_q * 32'(chCnt_q)) begin
            frameCnt_d = 32'h0000_0000;
            evtSet[`ADCSC_EVT_FRAME] = 1'b1; // R11
         end
         if (32'(wrIdx_d) >= bufLen_q) begin
            evtSet[`ADCSC_EVT_BUFFULL] = 1'b1; // R12
            evtSet[`ADCSC_EVT_HALT] = 1'b1;
         end
      end
      if (smpValid && !fifoInReady) evtSet[`ADCSC_EVT_OVF] = 1'b1; // R10
      evt_d = (evt_q & ~evtClr) | evtSet;
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         acq_q <= ACQ_IDLE;
         cnv_q <= CNV_IDLE;
         idx_q <= '0;
         wait_q <= 8'h00;
         scanPend_q <= 1'b0;
         tbAcc_q <= 32'h0000_0000;
         extClk_q <= 1'b0;
         drain_q <= 1'b0;
         wrIdx_q <= 16'h0000;
         frameCnt_q <= 32'h0000_0000;
         evt_q <= 4'h0;
      end else if (ce) begin
         acq_q <= acq_d;
         cnv_q <= cnv_d;
         idx_q <= idx_d;
         wait_q <= wait_d;
         scanPend_q <= scanPend_d;
         tbAcc_q <= tbAcc_d;
         extClk_q <= extClk_d;
         drain_q <= drain_d;
         wrIdx_q <= wrIdx_d;
         frameCnt_q <= frameCnt_d;
         evt_q <= evt_d;
      end
   end
endmodule : adcsc_core

// ==== src/adcsc_fifo.sv ====
`timescale 1ns/100ps
module adcsc_fifo #(
   parameter int WIDTH = 24,
   parameter int DEPTH = 8
) (
   input wire logic clk,
   input wire logic srst,
   input wire logic ce,
   input wire logic flush,
   input wire logic [WIDTH-1:0] inData,
   input wire logic inValid,
   output logic inReady,
   output logic [WIDTH-1:0] outData,
   output logic outValid,
   input wire logic outReady,
   output logic [$clog2(DEPTH):0] level
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0] wrPtr_q, wrPtr_d, rdPtr_q, rdPtr_d;
   logic [AW:0] cnt_q, cnt_d;
   logic push, pop;

   // honest full and empty from the occupancy count
   assign inReady = (cnt_q != DEPTH[AW:0]);
   assign outValid = (cnt_q != '0);
   assign outData = mem[rdPtr_q];
   assign level = cnt_q;
   assign push = inValid && inReady;
   assign pop = outValid && outReady;

   // pointer and count update
   always_comb begin
      wrPtr_d = wrPtr_q;
      rdPtr_d = rdPtr_q;
      cnt_d = cnt_q;
      if (flush) begin
         wrPtr_d = '0;
         rdPtr_d = '0;
         cnt_d = '0;
      end else begin
         if (push) wrPtr_d = (wrPtr_q == AW'(DEPTH - 1)) ? '0 : wrPtr_q + 1'b1;
         if (pop) rdPtr_d = (rdPtr_q == AW'(DEPTH - 1)) ? '0 : rdPtr_q + 1'b1;
         if (push && !pop) cnt_d = cnt_q + 1'b1;
         else if (pop && !push) cnt_d = cnt_q - 1'b1;
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         wrPtr_q <= '0;
         rdPtr_q <= '0;
         cnt_q <= '0;
      end else if (ce) begin
         wrPtr_q <= wrPtr_d;
         rdPtr_q <= rdPtr_d;
         cnt_q <= cnt_d;
      end
   end

   // storage has no reset
   always_ff @(posedge clk) begin
      if (ce && push && !flush) mem[wrPtr_q] <= inData;
   end
endmodule : adcsc_fifo

// ==== src/adcsc_pkg.sv ====
package adcsc_pkg;
   typedef enum logic [3:0] {
      ACQ_IDLE = 4'b0001,
      ACQ_ARMED = 4'b0010,
      ACQ_RUN = 4'b0100,
      ACQ_DONE = 4'b1000
   } adcsc_acq_t;
   typedef enum logic [2:0] {
      CNV_IDLE = 3'b001,
      CNV_SETTLE = 3'b010,
      CNV_CONV = 3'b100
   } adcsc_cnv_t;
   // one channel list entry
   typedef struct packed {
      logic slow;
      logic [7:0] chan;
   } adcsc_entry_t;
   // one sample toward the host
   typedef struct packed {
      logic [15:0] value;
      logic [7:0] chan;
   } adcsc_sample_t;
endpackage : adcsc_pkg

// ==== src/adcsc_regs.svh ====
`ifndef ADCSC_REGS_SVH
`define ADCSC_REGS_SVH
// register byte offsets
`define ADCSC_CTRL_OFS 8'h00
`define ADCSC_CMD_OFS 8'h04
`define ADCSC_DIV_OFS 8'h08
`define ADCSC_FRAME_OFS 8'h0C
`define ADCSC_BUFLEN_OFS 8'h10
`define ADCSC_STAT_OFS 8'h14
`define ADCSC_EVT_OFS 8'h18
`define ADCSC_CHLIST_OFS 8'h1C
`define ADCSC_CHCNT_OFS 8'h20
`define ADCSC_DATA_OFS 8'h24
// control bits
`define ADCSC_CTRL_CONVEN 0
`define ADCSC_CTRL_FASTTB 1
`define ADCSC_CTRL_SCANSRC0 2
`define ADCSC_CTRL_SCANSRC1 3
`define ADCSC_CTRL_HWTRIG 4
`define ADCSC_CTRL_BUSMASTER 5
// command bits
`define ADCSC_CMD_START 0
`define ADCSC_CMD_SWTRIG 1
`define ADCSC_CMD_SWCLK 2
`define ADCSC_CMD_FORCE 3
`define ADCSC_CMD_CLEAR 4
`define ADCSC_CMD_STOP 5
// event bits
`define ADCSC_EVT_FRAME 0
`define ADCSC_EVT_BUFFULL 1
`define ADCSC_EVT_HALT 2
`define ADCSC_EVT_OVF 3
// reset values
`define ADCSC_CTRL_RST 32'h0000_0000
`define ADCSC_DIV_RST 32'h0000_0064
// timing: conversion times in ns; fast and slow timebase ratio is 3
`define ADCSC_CONV_NS 1000
`define ADCSC_SETTLE_NS 2000
`define ADCSC_CLK_NS 50
`define ADCSC_CONV_CYC ((`ADCSC_CONV_NS + `ADCSC_CLK_NS - 1) / `ADCSC_CLK_NS)
`define ADCSC_SETTLE_CYC ((`ADCSC_SETTLE_NS + `ADCSC_CLK_NS - 1) / `ADCSC_CLK_NS)
`define ADCSC_TB_SLOW_STEP 16'h0001
`define ADCSC_TB_FAST_STEP 16'h0003
`endif

// ==== tb/adc_scan_fifo_transfer_tb.sv ====
`timescale 1ns/100ps
`include "adcsc_regs.svh"
module adc_scan_fifo_transfer_tb import adcsc_pkg::*;;
   typedef struct {logic [7:0] a; logic [31:0] d; logic [1:0] r;} adcsc_row_t;
   logic clk, srst, ce, extScanClk, hwStartTrig, adcStart, adcDone, hostValid, hostReady, stall, fast;
   logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
   logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
   logic [7:0] s_axi_awaddr, s_axi_araddr, adcChan;
   logic [31:0] s_axi_wdata, s_axi_rdata;
   logic [3:0] s_axi_wstrb;
   logic [1:0] s_axi_bresp, s_axi_rresp, lastB;
   logic [15:0] adcData, hostWrIndex;
   adcsc_sample_t hostData;
   adcsc_sample_t q[$];
   int n_fail = 0, n_tests = 0;
   adcsc_row_t rows[8] = '{'{`ADCSC_CTRL_OFS, `ADCSC_CTRL_RST, 2'h0}, '{`ADCSC_DIV_OFS, `ADCSC_DIV_RST, 2'h0},
      '{`ADCSC_FRAME_OFS, 32'h10, 2'h0}, '{`ADCSC_BUFLEN_OFS, 32'h40, 2'h0}, '{`ADCSC_CHCNT_OFS, 32'h1, 2'h0},
      '{`ADCSC_STAT_OFS, 32'h1, 2'h0}, '{`ADCSC_EVT_OFS, 32'h0, 2'h0}, '{8'h30, 32'h0, 2'h2}};
   adcsc_core i_dut (.clk, .srst, .ce, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
      .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
      .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .extScanClk,
      .hwStartTrig, .adcChan, .adcStart, .adcData, .adcDone, .hostData, .hostValid, .hostReady, .hostWrIndex);
   adcsc_host_model i_host (.clk, .srst, .adcStart, .adcDone, .adcData, .stall, .fast, .hostReady);
   ////////////////////////////////////////////////////////////////
   // verdict and comparison
   task automatic tally_and_finish;
      $display("tests %0d fails %0d", n_tests, n_fail);
      if (n_fail == 0 && n_tests > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask : tally_and_finish
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         n_fail++;
         $display("ERROR %0t got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic tmo;
      n_fail++;
      $display("ERROR %0t wait ran out", $time);
      tally_and_finish();
   endtask : tmo
   ////////////////////////////////////////////////////////////////
   // register bus master
   task automatic axw(input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         @(posedge clk);
         n++;
         if (s_axi_awvalid && s_axi_awready) begin
            s_axi_awvalid <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            s_axi_wvalid <= 1'b0;
         end
      end while (!s_axi_bvalid && n < 100);
      lastB = s_axi_bresp;
      s_axi_bready <= 1'b0;
      if (n >= 100) begin
         tmo();
      end
   endtask : axw
   task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      int n;
      n = 0;
      @(posedge clk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
         @(posedge clk);
         n++;
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arvalid <= 1'b0;
         end
      end while (!s_axi_rvalid && n < 100);
      d = s_axi_rdata;
      r = s_axi_rresp;
      s_axi_rready <= 1'b0;
      if (n >= 100) begin
         tmo();
      end
   endtask : axr
   ////////////////////////////////////////////////////////////////
   // commands and status checks
   task automatic cmd(input int b);
      axw(`ADCSC_CMD_OFS, 32'h0000_0001 << b);
      repeat (300) @(posedge clk);
   endtask : cmd
   task automatic rdm(input logic [7:0] a, input logic [31:0] m, input logic [31:0] exp);
      logic [31:0] d;
      logic [1:0] r;
      axr(a, d, r);
      chk(d & m, exp);
   endtask : rdm
   // capture every sample handed to the host
   always @(posedge clk) begin
      if (!srst && hostValid && hostReady) begin
         q.push_back(hostData);
      end
   end
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   ////////////////////////////////////////////////////////////////
   // main sequence
   initial begin
      logic [31:0] d;
      logic [1:0] r;
      {srst, ce, s_axi_wstrb} = 6'h3F;
      {extScanClk, hwStartTrig, stall, fast, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 7'h09;
      {s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
      repeat (6) @(posedge clk);
      srst <= 1'b0;
      foreach (rows[i]) begin
         axr(rows[i].a, d, r);
         chk(d, rows[i].d);
         chk({30'h0, r}, {30'h0, rows[i].r});
      end
      axw(8'h30, 32'h0000_00FF);
      chk({30'h0, lastB}, 32'h2);
      // two entries, second one slow; one scan per frame
      axw(`ADCSC_CHLIST_OFS, 32'h0000_0005);
      axw(`ADCSC_CHLIST_OFS, 32'h0001_0106);
      axw(`ADCSC_CHCNT_OFS, 32'h0000_0002);
      axw(`ADCSC_FRAME_OFS, 32'h0000_0001);
      axw(`ADCSC_CTRL_OFS, 32'h0000_0001);
      cmd(`ADCSC_CMD_START);
      rdm(`ADCSC_STAT_OFS, 32'h0F, 32'h2);
      cmd(`ADCSC_CMD_SWTRIG);
      rdm(`ADCSC_STAT_OFS, 32'h0F, 32'h4);
      cmd(`ADCSC_CMD_SWCLK);
      rdm(`ADCSC_STAT_OFS, 32'hF00, 32'h200);
      chk({24'h0, adcChan}, 32'h6);
      chk({16'h0, hostWrIndex}, 32'h0);
      cmd(`ADCSC_CMD_SWCLK);
      chk({16'h0, hostWrIndex}, 32'h4);
      chk({8'h0, q[0]}, {8'h0, 16'h1001, 8'h05});
      chk({24'h0, q[1].chan}, 32'h6);
      rdm(`ADCSC_EVT_OFS, 32'h1, 32'h1);
      // conversions off then on, no reconfiguration
      axw(`ADCSC_CTRL_OFS, 32'h0000_0000);
      cmd(`ADCSC_CMD_SWCLK);
      rdm(`ADCSC_STAT_OFS, 32'hF00, 32'h0);
      axw(`ADCSC_CTRL_OFS, 32'h0000_0001);
      cmd(`ADCSC_CMD_SWCLK);
      rdm(`ADCSC_STAT_OFS, 32'hF00, 32'h200);
      cmd(`ADCSC_CMD_FORCE);
      chk({16'h0, hostWrIndex}, 32'h6);
      // forced update ignored under bus mastering, then clear
      axw(`ADCSC_CTRL_OFS, 32'h0000_0021);
      cmd(`ADCSC_CMD_SWCLK);
      cmd(`ADCSC_CMD_FORCE);
      rdm(`ADCSC_STAT_OFS, 32'hF00, 32'h200);
      chk({16'h0, hostWrIndex}, 32'h6);
      cmd(`ADCSC_CMD_CLEAR);
      rdm(`ADCSC_STAT_OFS, 32'hF00, 32'h0);
      // host stalls until the sample store overflows
      axw(`ADCSC_CTRL_OFS, 32'h0000_0001);
      stall <= 1'b1;
      repeat (5) cmd(`ADCSC_CMD_SWCLK);
      rdm(`ADCSC_STAT_OFS, 32'hF00, 32'h800);
      rdm(`ADCSC_EVT_OFS, 32'h8, 32'h8);
      stall <= 1'b0;
      repeat (100) @(posedge clk);
      chk({16'h0, hostWrIndex}, 32'hE);
      // restart into a short buffer with a slow host
      axw(`ADCSC_EVT_OFS, 32'h0000_000F);
      axw(`ADCSC_BUFLEN_OFS, 32'h0000_0008);
      fast <= 1'b0;
      cmd(`ADCSC_CMD_STOP);
      cmd(`ADCSC_CMD_START);
      chk({16'h0, hostWrIndex}, 32'h0);
      rdm(`ADCSC_STAT_OFS, 32'h0F, 32'h2);
      cmd(`ADCSC_CMD_SWTRIG);
      repeat (4) cmd(`ADCSC_CMD_SWCLK);
      chk({16'h0, hostWrIndex}, 32'h8);
      rdm(`ADCSC_EVT_OFS, 32'h6, 32'h6);
      rdm(`ADCSC_STAT_OFS, 32'h0F, 32'h8);
      tally_and_finish();
   end
endmodule : adc_scan_fifo_transfer_tb
bind adcsc_core adcsc_assertions i_chk (.clk, .srst, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
   .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid,
   .s_axi_rready, .adcStart, .adcDone, .hostData, .hostValid, .hostReady, .hostWrIndex);

// ==== tb/adcsc_assertions.sv ====
`timescale 1ns/100ps
module adcsc_assertions import adcsc_pkg::*; (
   input wire logic clk,
   input wire logic srst,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic adcStart,
   input wire logic adcDone,
   input wire adcsc_sample_t hostData,
   input wire logic hostValid,
   input wire logic hostReady,
   input wire logic [15:0] hostWrIndex
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (srst);
   logic pend_q, pend_d;
   ////////////////////////////////////////////////////////////////
   // conversion outstanding between start pulse and done
   always_comb begin
      pend_d = pend_q;
      if (adcStart) begin
         pend_d = 1'b1;
      end else if (adcDone) begin
         pend_d = 1'b0;
      end
   end
   always_ff @(posedge clk) begin
      if (srst) begin
         pend_q <= 1'b0;
      end else begin
         pend_q <= pend_d;
      end
   end
   ////////////////////////////////////////////////////////////////
   // both write halves taken in one cycle
   sequence wrTaken;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   endsequence
   sequence rdTaken;
      s_axi_arvalid && s_axi_arready;
   endsequence
   a_write_resp: assert property (wrTaken |-> ##[1:2] s_axi_bvalid)
      else $error("write response late");
   a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response dropped");
   a_read_resp: assert property (rdTaken |=> s_axi_rvalid)
      else $error("read response late");
   a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data dropped");
   a_host_hold: assert property (hostValid && !hostReady |=> hostValid && $stable(hostData))
      else $error("host sample dropped while stalled");
   a_index_step: assert property (hostValid && hostReady |=> hostWrIndex == $past(hostWrIndex) + 16'h0001)
      else $error("host index did not step");
   a_start_pulse: assert property (adcStart |=> !adcStart)
      else $error("start pulse too long");
   a_one_pending: assert property (adcStart |-> !pend_q || adcDone)
      else $error("start while conversion pending");
endmodule : adcsc_assertions

// ==== tb/adcsc_host_model.sv ====
`timescale 1ns/100ps
module adcsc_host_model (
   input wire logic clk,
   input wire logic srst,
   input wire logic adcStart,
   output logic adcDone,
   output logic [15:0] adcData,
   input wire logic stall,
   input wire logic fast,
   output logic hostReady
);
   logic busy_q;
   logic [1:0] cnt_q;
   logic [15:0] val_q;
   ////////////////////////////////////////////////////////////////
   // converter: done five cycles after start, new value each time
   always_ff @(posedge clk) begin
      if (srst) begin
         busy_q <= 1'b0;
         cnt_q <= 2'h0;
         val_q <= 16'h1000;
         adcDone <= 1'b0;
      end else begin
         adcDone <= busy_q && cnt_q == 2'h3;
         cnt_q <= adcStart ? 2'h0 : cnt_q + 2'h1;
         if (adcStart) begin
            busy_q <= 1'b1;
         end else if (busy_q && cnt_q == 2'h3) begin
            busy_q <= 1'b0;
            val_q <= val_q + 16'h0001;
         end
      end
   end
   // data bus shows garbage outside the done pulse
   assign adcData = adcDone ? val_q : ~val_q;
   // host sink: stalls on request, else prompt or every other cycle
   always_ff @(posedge clk) begin
      if (srst) begin
         hostReady <= 1'b0;
      end else begin
         hostReady <= !stall && (fast || !hostReady);
      end
   end
endmodule : adcsc_host_model
